// *** sim/gpio_pin_config_output_bench.sv ***
// testbench: programs the pin bank over the two-wire bus and checks pins and read-back
`timescale 1ns/1ps

module gpio_pin_config_output_bench;
  logic       clock_i;
  logic       reset_i;
  logic       scl;
  logic       host_pull;
  logic       addr_sel;
  logic [7:0] pin_level;
  logic       dev_sda;
  logic       dev_sda_oe;
  logic [7:0] pin_out;
  logic [7:0] pin_oe;
  logic [7:0] pull_up;
  logic [7:0] pull_dn;
  logic       hold_en;
  int         fail_count;
  int         tests_run;
  logic [7:0] r0;
  logic [7:0] r1;
  // open drain with pull-up: low if either party pulls
  wire        sda_line = ~(host_pull | dev_sda_oe);
  wire  [6:0] dev_addr = {gpio_cfg_pkg::DEV_ADDR_BASE[6:1], addr_sel};

  gpio_pin_config_output gpio_pin_config_output_i (.clock_i(clock_i), .reset_i(reset_i), .scl_i(scl),
    .sda_i(sda_line), .sda_o(dev_sda), .sda_oe_o(dev_sda_oe), .addr_sel_i(addr_sel), .pin_level_i(pin_level),
    .pin_out_o(pin_out), .pin_oe_o(pin_oe), .pull_up_o(pull_up), .pull_dn_o(pull_dn), .hold_en_o(hold_en));
  host_model host_model_i (.clock_i(clock_i), .sda_i(sda_line), .scl_o(scl), .sda_pull_o(host_pull));

  // ------------------------------------------------------------
  // checking and bus helpers
  // ------------------------------------------------------------
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic send(input logic [7:0] b);
    logic a;
    host_model_i.wr_byte(b, a);
    check("byte ack", {7'h00, a}, 8'h01);
  endtask

  task automatic wr(input logic [7:0] cmd, input logic [7:0] d0, input logic [7:0] d1, input bit two);
    host_model_i.start();
    send({dev_addr, 1'b0});
    send(cmd);
    send(d0);
    if (two) begin
      send(d1);
    end
    host_model_i.stop();
  endtask

  task automatic rd(input logic [7:0] cmd);
    host_model_i.start();
    send({dev_addr, 1'b0});
    send(cmd);
    host_model_i.start();
    send({dev_addr, 1'b1});
    host_model_i.rd_byte(r0, 1'b0);
    host_model_i.rd_byte(r1, 1'b1);
    host_model_i.stop();
  endtask

  task automatic pulls(input logic [7:0] up, input logic [7:0] dn, input logic hold);
    check("pull_up", pull_up, up);
    check("pull_dn", pull_dn, dn);
    check("hold_en", {7'h00, hold_en}, {7'h00, hold});
  endtask

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic sc_reset();
    check("pin_oe reset", pin_oe, 8'h00);
    check("pin_out reset", pin_out, 8'h00);
    check("sda_o", {7'h00, dev_sda}, 8'h00);
    pulls(8'h00, 8'h00, 1'b0);
    rd(8'h82); // increment flag set: bank then selector
    check("bank reset low bits", r0 & 8'h03, 8'h00);
    check("selector reset", r1, 8'hFF);
    rd(8'h84);
    check("direction reset", r0, 8'hFF);
    check("output reset", r1, 8'h00);
  endtask

  task automatic sc_pulls();
    wr(8'h02, 8'h02, 8'h00, 1'b0);
    pulls(8'hFF, 8'h00, 1'b0);
    wr(8'h03, 8'hA5, 8'h00, 1'b0);
    pulls(8'hA5, 8'h5A, 1'b0);
    wr(8'h02, 8'h00, 8'h00, 1'b0);
    pulls(8'h00, 8'h00, 1'b0);
    wr(8'h02, 8'h03, 8'h00, 1'b0);
    pulls(8'h00, 8'h00, 1'b1);
    wr(8'h03, 8'h0F, 8'h00, 1'b0);
    pulls(8'h00, 8'h00, 1'b1);
    wr(8'h02, 8'hFE, 8'h00, 1'b0);
    pulls(8'h0F, 8'hF0, 1'b0);
    rd(8'h82);
    check("bank upper bits", r0, 8'hFE);
    check("selector readback", r1, 8'h0F);
  endtask

  task automatic sc_dir_out();
    wr(8'h84, 8'hF0, 8'h3C, 1'b1);
    check("pin_oe", pin_oe, 8'h0F);
    check("input pins released", pin_oe & 8'hF0, 8'h00);
    check("pin_out", pin_out, 8'h0C);
    rd(8'h05); // no increment: same register twice
    check("output stored", r0, 8'h3C);
    check("no increment", r1, 8'h3C);
    rd(8'h87); // pointer wraps from 7 to the input register
    check("input after wrap", r1, pin_level);
  endtask

  // a foreign address must get no ack
  task automatic sc_bad_addr();
    logic a;
    host_model_i.start();
    host_model_i.wr_byte({dev_addr ^ 7'h01, 1'b0}, a);
    host_model_i.stop();
    check("foreign address ack", {7'h00, a}, 8'h00);
  endtask

  // reset in mid-run, with every register away from its default, must restore all of them
  task automatic sc_mid_reset();
    reset_i <= 1'b1;
    repeat (5) @(posedge clock_i);
    reset_i <= 1'b0;
    repeat (5) @(posedge clock_i);
    sc_reset();
  endtask

  task automatic results();
    $display("Checks run %0d, mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("Test passed");
    end
    else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // ------------------------------------------------------------
  // clock, watchdog and main sequence
  // ------------------------------------------------------------
  initial begin
    clock_i = 1'b0;
    forever #10 clock_i = ~clock_i;
  end

  // a hung run counts as a mismatch
  initial begin
    repeat (100000) @(posedge clock_i);
    fail_count++;
    results();
  end

  initial begin
    fail_count = 0;
    tests_run  = 0;
    reset_i    = 1'b1;
    addr_sel   = 1'b1;
    pin_level  = 8'hC3;
    repeat (5) @(posedge clock_i);
    reset_i <= 1'b0;
    repeat (5) @(posedge clock_i);
    sc_reset();
    sc_pulls();
    sc_dir_out();
    sc_bad_addr();
    sc_mid_reset();
    results();
  end
endmodule

// *** sim/host_model.sv ***
// partner model: two-wire bus master that drives the serial clock and pulls the open-drain data line
`timescale 1ns/1ps

module host_model (
  // clock
  input  wire logic clock_i,
  // bus
  input  wire logic sda_i,
  output logic      scl_o,
  output logic      sda_pull_o
);
  // ------------------------------------------------------------
  // timing: 8 clocks a bit; low phase is long so the device's
  // ack release lands well before the next clock rise
  // ------------------------------------------------------------
  task automatic wait_n(input int n);
    repeat (n) @(posedge clock_i);
  endtask

  // bus idle: clock high, data released to the pull-up
  initial begin
    scl_o      = 1'b1;
    sda_pull_o = 1'b0;
  end

  // start or repeated start: data falls while clock is high
  task automatic start();
    sda_pull_o <= 1'b0;
    wait_n(2);
    scl_o <= 1'b1;
    wait_n(4);
    sda_pull_o <= 1'b1;
    wait_n(4);
    scl_o <= 1'b0;
    wait_n(4);
  endtask

  // stop: data rises while clock is high
  task automatic stop();
    sda_pull_o <= 1'b1;
    wait_n(2);
    scl_o <= 1'b1;
    wait_n(4);
    sda_pull_o <= 1'b0;
    wait_n(4);
  endtask

  task automatic bit_out(input logic b);
    sda_pull_o <= ~b;
    wait_n(2);
    scl_o <= 1'b1;
    wait_n(2);
    scl_o <= 1'b0;
    wait_n(4);
  endtask

  // sample away from the clock edge so the device's register update has landed
  task automatic bit_in(output logic b);
    sda_pull_o <= 1'b0;
    wait_n(2);
    scl_o <= 1'b1;
    wait_n(1);
    @(negedge clock_i);
    b = sda_i;
    wait_n(1);
    scl_o <= 1'b0;
    wait_n(4);
  endtask

  // byte out msb first, then the ninth bit comes back as the ack
  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic a;
    for (int i = 7; i >= 0; i--) begin
      bit_out(d[i]);
    end
    bit_in(a);
    ack = ~a;
  endtask

  // byte in msb first; last byte is refused so the device lets go
  task automatic rd_byte(output logic [7:0] d, input logic last);
    for (int i = 7; i >= 0; i--) begin
      bit_in(d[i]);
    end
    bit_out(last);
  endtask
endmodule

// *** verilog/gpio_cfg_pkg.sv ***
// package: register offsets, field positions, reset values and states of the pin configuration bank
package gpio_cfg_pkg;

  // ----------------------------------------------------------------
  // register pointer values (low three bits of the command byte)
  // ----------------------------------------------------------------
  localparam logic [2:0] OFS_INPUT    = 3'h0;
  localparam logic [2:0] OFS_BANK     = 3'h2;
  localparam logic [2:0] OFS_PULL_SEL = 3'h3;
  localparam logic [2:0] OFS_DIR      = 3'h4;
  localparam logic [2:0] OFS_OUT      = 3'h5;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int HOLD_BIT = 0;   // hold_enable_bit in bank_hold_pull_enable
  localparam int PULL_BIT = 1;   // pull_enable_bit in bank_hold_pull_enable
  localparam int AI_BIT   = 7;   // pointer_increment_flag in the command byte

  // ----------------------------------------------------------------
  // values after reset
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_BANK     = 8'h00;
  localparam logic [7:0] RST_PULL_SEL = 8'hFF;
  localparam logic [7:0] RST_DIR      = 8'hFF;
  localparam logic [7:0] RST_OUT      = 8'h00;
  localparam logic [7:0] RST_BYTE     = 8'h00;
  localparam logic [2:0] RST_PTR      = 3'h0;

  // ----------------------------------------------------------------
  // serial link constants
  // ----------------------------------------------------------------
  localparam logic [6:0] DEV_ADDR_BASE = 7'h20;  // select pin supplies bit 0
  localparam logic [3:0] BIT_LAST      = 4'h7;
  localparam logic [3:0] BIT_FULL      = 4'h8;
  localparam logic [3:0] BIT_ZERO      = 4'h0;

  // ----------------------------------------------------------------
  // protocol states
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    st_idle,
    st_addr,
    st_addr_ack,
    st_cmd,
    st_cmd_ack,
    st_wdata,
    st_wdata_ack,
    st_rdata,
    st_rdata_ack
  } link_state_t;

endpackage

// *** verilog/gpio_pin_config_output.sv ***
// design: serial-bus register bank holding pull, hold, direction and output level settings of eight pins
`timescale 1ns/1ps

module gpio_pin_config_output (
  // clock and reset
  input  wire logic       clock_i,
  input  wire logic       reset_i,
  // serial link (open drain data)
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  output logic            sda_o,
  output logic            sda_oe_o,
  input  wire logic       addr_sel_i,
  // pin bank
  input  wire logic [7:0] pin_level_i,
  output logic      [7:0] pin_out_o,
  output logic      [7:0] pin_oe_o,
  output logic      [7:0] pull_up_o,
  output logic      [7:0] pull_dn_o,
  output logic            hold_en_o
);

  // cleared byte value for shift and read paths; declared ahead of every use
  localparam logic [7:0] RST_BYTE_C = gpio_cfg_pkg::RST_BYTE;

  // ----------------------------------------------------------------
  // synchronisers and edge detection
  // ----------------------------------------------------------------
  logic       scl_m_r, scl_s_r, scl_d_r;
  logic       sda_m_r, sda_s_r, sda_d_r;
  logic       sel_m_r, sel_s_r;
  logic [7:0] pin_m_r, pin_s_r;

  // two stages per pin; the third scl/sda stage only feeds edge detection
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      {scl_m_r, scl_s_r, scl_d_r} <= 3'h7;
      {sda_m_r, sda_s_r, sda_d_r} <= 3'h7;
      {sel_m_r, sel_s_r}          <= 2'h0;
      pin_m_r                     <= RST_BYTE_C;
      pin_s_r                     <= RST_BYTE_C;
    end else begin
      {scl_m_r, scl_s_r, scl_d_r} <= {scl_i, scl_m_r, scl_s_r};
      {sda_m_r, sda_s_r, sda_d_r} <= {sda_i, sda_m_r, sda_s_r};
      {sel_m_r, sel_s_r}          <= {addr_sel_i, sel_m_r};
      pin_m_r                     <= pin_level_i;
      pin_s_r                     <= pin_m_r;
    end
  end

  wire logic scl_rise  = scl_s_r & ~scl_d_r;
  wire logic scl_fall  = ~scl_s_r & scl_d_r;
  wire logic start_det = scl_s_r & scl_d_r & sda_d_r & ~sda_s_r;
  wire logic stop_det  = scl_s_r & scl_d_r & ~sda_d_r & sda_s_r;

  // ----------------------------------------------------------------
  // protocol state
  // ----------------------------------------------------------------
  gpio_cfg_pkg::link_state_t state_r;
  logic [3:0] cnt_r;
  logic [7:0] sh_r;
  logic [2:0] ptr_r;
  logic       ai_r;
  logic       rw_r;
  logic       nack_r;
  logic       sda_oe_r;
  logic [7:0] bank_r, sel_r, dir_r, out_r;
  logic [7:0] rd_data;

  // decode of the current state and of the byte just shifted in
  wire logic rx_state  = (state_r == gpio_cfg_pkg::st_addr) | (state_r == gpio_cfg_pkg::st_cmd) |
                         (state_r == gpio_cfg_pkg::st_wdata);
  wire logic byte_full = (cnt_r == gpio_cfg_pkg::BIT_FULL);
  wire logic addr_hit  = (sh_r[7:1] == {gpio_cfg_pkg::DEV_ADDR_BASE[6:1], sel_s_r});
  wire logic wr_commit = scl_fall & (state_r == gpio_cfg_pkg::st_wdata_ack);
  wire logic load_rd   = scl_fall & (((state_r == gpio_cfg_pkg::st_addr_ack) & rw_r) |
                                     ((state_r == gpio_cfg_pkg::st_rdata_ack) & ~nack_r));
  wire logic [2:0] ptr_step = ptr_r + {2'h0, ai_r};   // 3 bits, so 7 wraps to 0

  // read selection; the input register sees the synchronised pins
  assign rd_data = (ptr_r == gpio_cfg_pkg::OFS_INPUT)    ? pin_s_r :
                   (ptr_r == gpio_cfg_pkg::OFS_BANK)     ? bank_r  :
                   (ptr_r == gpio_cfg_pkg::OFS_PULL_SEL) ? sel_r   :
                   (ptr_r == gpio_cfg_pkg::OFS_DIR)      ? dir_r   :
                   (ptr_r == gpio_cfg_pkg::OFS_OUT)      ? out_r   :
                   RST_BYTE_C;

  // byte engine: bits are taken on scl rise, sda changes only on scl fall
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      state_r  <= gpio_cfg_pkg::st_idle;
      cnt_r    <= gpio_cfg_pkg::BIT_ZERO;
      sh_r     <= RST_BYTE_C;
      ptr_r    <= gpio_cfg_pkg::RST_PTR;
      ai_r     <= 1'b0;
      rw_r     <= 1'b0;
      nack_r   <= 1'b0;
      sda_oe_r <= 1'b0;
    end else if (start_det) begin
      state_r  <= gpio_cfg_pkg::st_addr;
      cnt_r    <= gpio_cfg_pkg::BIT_ZERO;
      sda_oe_r <= 1'b0;
    end else if (stop_det) begin
      state_r  <= gpio_cfg_pkg::st_idle;
      sda_oe_r <= 1'b0;
    end else if (scl_rise) begin
      if (rx_state && !byte_full) begin
        sh_r  <= {sh_r[6:0], sda_s_r};
        cnt_r <= cnt_r + 4'h1;
      end
      if (state_r == gpio_cfg_pkg::st_rdata_ack) begin
        nack_r <= sda_s_r;
      end
    end else if (scl_fall) begin
      unique case (state_r)
        gpio_cfg_pkg::st_addr: begin
          if (byte_full) begin
            state_r  <= addr_hit ? gpio_cfg_pkg::st_addr_ack : gpio_cfg_pkg::st_idle;
            sda_oe_r <= addr_hit;
            rw_r     <= sh_r[0];
          end
        end
        gpio_cfg_pkg::st_cmd: begin
          if (byte_full) begin
            state_r  <= gpio_cfg_pkg::st_cmd_ack;
            sda_oe_r <= 1'b1;
            ptr_r    <= sh_r[2:0];
            ai_r     <= sh_r[gpio_cfg_pkg::AI_BIT];
          end
        end
        gpio_cfg_pkg::st_wdata: begin
          if (byte_full) begin
            state_r  <= gpio_cfg_pkg::st_wdata_ack;
            sda_oe_r <= 1'b1;
          end
        end
        gpio_cfg_pkg::st_addr_ack,
        gpio_cfg_pkg::st_rdata_ack: begin
          cnt_r <= gpio_cfg_pkg::BIT_ZERO;
          if (load_rd) begin
            state_r  <= gpio_cfg_pkg::st_rdata;
            sh_r     <= rd_data;
            sda_oe_r <= ~rd_data[7];
          end else begin
            state_r  <= rw_r ? gpio_cfg_pkg::st_idle : gpio_cfg_pkg::st_cmd;
            sda_oe_r <= 1'b0;
          end
        end
        gpio_cfg_pkg::st_cmd_ack,
        gpio_cfg_pkg::st_wdata_ack: begin
          state_r  <= gpio_cfg_pkg::st_wdata;
          cnt_r    <= gpio_cfg_pkg::BIT_ZERO;
          sda_oe_r <= 1'b0;
          if (state_r == gpio_cfg_pkg::st_wdata_ack) begin
            ptr_r <= ptr_step;
          end
        end
        gpio_cfg_pkg::st_rdata: begin
          cnt_r <= cnt_r + 4'h1;
          if (cnt_r == gpio_cfg_pkg::BIT_LAST) begin
            state_r  <= gpio_cfg_pkg::st_rdata_ack;
            sda_oe_r <= 1'b0;                            // master owns the ack slot
            ptr_r    <= ptr_step;
          end else begin
            sh_r     <= {sh_r[6:0], 1'b0};
            sda_oe_r <= ~sh_r[6];
          end
        end
        default: begin
          state_r <= gpio_cfg_pkg::st_idle;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // settings registers
  // ----------------------------------------------------------------
  // written only at the end of the acknowledge bit, so an aborted byte changes nothing
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      bank_r <= gpio_cfg_pkg::RST_BANK;
      sel_r  <= gpio_cfg_pkg::RST_PULL_SEL;
      dir_r  <= gpio_cfg_pkg::RST_DIR;
      out_r  <= gpio_cfg_pkg::RST_OUT;
    end else if (wr_commit) begin
      if (ptr_r == gpio_cfg_pkg::OFS_BANK) bank_r <= sh_r;
      if (ptr_r == gpio_cfg_pkg::OFS_PULL_SEL) sel_r <= sh_r;
      if (ptr_r == gpio_cfg_pkg::OFS_DIR) dir_r <= sh_r;
      if (ptr_r == gpio_cfg_pkg::OFS_OUT) out_r <= sh_r;
    end
  end

  // ----------------------------------------------------------------
  // pin drive
  // ----------------------------------------------------------------
  // hold wins over pulls, so selector writes under hold stay invisible
  wire logic hold_on = bank_r[gpio_cfg_pkg::HOLD_BIT];
  wire logic pull_on = bank_r[gpio_cfg_pkg::PULL_BIT] & ~hold_on;

  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      hold_en_o <= 1'b0;
      sda_o     <= 1'b0;
    end else begin
      hold_en_o <= hold_on;
      sda_o     <= 1'b0;                     // open drain: only the enable toggles
    end
  end

  assign sda_oe_o = sda_oe_r;

  // one set of drive flops per pin
  for (genvar i = 0; i < 8; i++) begin : g_pin
    always_ff @(posedge clock_i or posedge reset_i) begin
      if (reset_i) begin
        pin_oe_o[i]  <= 1'b0;
        pin_out_o[i] <= 1'b0;
        pull_up_o[i] <= 1'b0;
        pull_dn_o[i] <= 1'b0;
      end else begin
        pin_oe_o[i]  <= ~dir_r[i];
        pin_out_o[i] <= out_r[i] & ~dir_r[i];
        pull_up_o[i] <= pull_on & sel_r[i];
        pull_dn_o[i] <= pull_on & ~sel_r[i];
      end
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  // one clock domain, so a single default clocking and disable serve every check
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (reset_i);

  // pin-side outputs are one register stage behind the settings
  chk_hold_follow: assert property (
    1'b1 |=> hold_en_o == $past(bank_r[gpio_cfg_pkg::HOLD_BIT]))
    else $error("hold output does not follow bank bit 0");
  // hold and pulls must never act on a pin together
  chk_hold_no_pull: assert property (
    hold_en_o |-> (pull_up_o == 8'h00) && (pull_dn_o == 8'h00))
    else $error("pull active while bus-hold on");
  chk_pull_apply: assert property (
    bank_r[gpio_cfg_pkg::PULL_BIT] && !bank_r[gpio_cfg_pkg::HOLD_BIT] |=>
    (pull_up_o == $past(sel_r)) && (pull_dn_o == ~$past(sel_r)))
    else $error("pull direction not taken from selector");
  chk_pull_off: assert property (
    !bank_r[gpio_cfg_pkg::PULL_BIT] |=> (pull_up_o | pull_dn_o) == 8'h00)
    else $error("pull active while pulls disabled");
  // two cycles of hold cover the register stage between selector and pins
  chk_sel_ignored: assert property (
    bank_r[gpio_cfg_pkg::HOLD_BIT] ##1 bank_r[gpio_cfg_pkg::HOLD_BIT] |=>
    $stable(pull_up_o) && $stable(pull_dn_o))
    else $error("selector write changed pulls under hold");
  // upper bank bits are plain storage, so only the two control bits are checked
  chk_reset_values: assert property (
    $past(reset_i) |-> (bank_r[1:0] == gpio_cfg_pkg::RST_BANK[1:0]) &&
    (sel_r == gpio_cfg_pkg::RST_PULL_SEL) &&
    (dir_r == gpio_cfg_pkg::RST_DIR) && (out_r == gpio_cfg_pkg::RST_OUT))
    else $error("register reset value wrong");
  chk_dir_drive: assert property (
    1'b1 |=> pin_oe_o == ~$past(dir_r))
    else $error("output enable does not match direction");
  chk_out_masked: assert property (
    1'b1 |=> (pin_out_o & $past(dir_r)) == 8'h00)
    else $error("output level on an input pin");
  // output read-back must come from the stored bits, input read-back from the synchronised pins
  chk_out_readback: assert property (
    load_rd && (ptr_r == gpio_cfg_pkg::OFS_OUT) |=> sh_r == $past(out_r))
    else $error("output register read not from flip-flops");
  chk_in_readback: assert property (
    load_rd && (ptr_r == gpio_cfg_pkg::OFS_INPUT) |=> sh_r == $past(pin_s_r))
    else $error("input register read not from the pins");
  // pointer moves by the increment flag only, three bits so it wraps
  chk_ptr_step: assert property (
    wr_commit |=> ptr_r == $past(ptr_r) + {2'h0, $past(ai_r)})
    else $error("pointer did not advance per increment flag");
  chk_ptr_fixed: assert property (
    scl_fall && (state_r == gpio_cfg_pkg::st_rdata) && (cnt_r == gpio_cfg_pkg::BIT_LAST) && !ai_r |=>
    $stable(ptr_r))
    else $error("pointer moved on a read without increment flag");
  // commit edge, register edge, then the pin output edge
  chk_write_commit: assert property (
    wr_commit && (ptr_r == gpio_cfg_pkg::OFS_DIR) |=> ##1 pin_oe_o == ~$past(sh_r, 2))
    else $error("direction write not applied after acknowledge");

endmodule
